//--- hdl/fmtd_top.v
`timescale 1ns/100ps
`default_nettype none
`include "fmtd_defines.vh"

// freefall/motion threshold compare and debounce control
module fmtd_top #(
	parameter CNT_W = 8
) (
	// clock and reset
	input wire clk,
	input wire rstn,
	// register access from the serial interface decoder
	input wire reg_wr_en,
	input wire reg_rd_en,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	output reg [7:0] reg_rdata,
	// acceleration samples, same clock domain
	input wire sample_valid,
	input wire signed [`FMTD_DATA_W-1:0] accel_x,
	input wire signed [`FMTD_DATA_W-1:0] accel_y,
	input wire signed [`FMTD_DATA_W-1:0] accel_z,
	// configuration held in neighbouring registers
	input wire motion_select,
	input wire x_enable,
	input wire y_enable,
	input wire z_enable,
	input wire [1:0] full_scale_range,
	input wire [CNT_W-1:0] debounce_target,
	// detection results
	output wire event_active,
	output wire [CNT_W-1:0] debounce_count,
	output reg [2:0] axis_hit_r,
	output reg [2:0] axis_negative_r,
	output wire per_axis_mode,
	output wire transient_share
);

	// reset synchroniser stages
	reg rst_meta_n_r;
	reg rst_sync_n_r;

	// common threshold and clear mode
	reg [7:0] common_r;
	// x high bits plus per-axis select
	reg [7:0] x_high_r;
	// x low bits
	reg [5:0] x_low_r;
	// y high bits plus transient share flag
	reg [7:0] y_high_r;
	// y low bits
	reg [5:0] y_low_r;
	// z high bits, top bit unused
	reg [6:0] z_high_r;
	// z low bits
	reg [5:0] z_low_r;

	// decoded fields
	wire clear_mode;
	wire [6:0] shared_ths;
	wire [`FMTD_THS_W-1:0] x_ths;
	wire [`FMTD_THS_W-1:0] y_ths;
	wire [`FMTD_THS_W-1:0] z_ths;
	wire [`FMTD_CMP_W-1:0] shared_eff;
	wire [`FMTD_CMP_W-1:0] x_eff;
	wire [`FMTD_CMP_W-1:0] y_eff;
	wire [`FMTD_CMP_W-1:0] z_eff;

	// per-axis compare results
	wire x_below;
	wire x_above;
	wire x_neg;
	wire y_below;
	wire y_above;
	wire y_neg;
	wire z_below;
	wire z_above;
	wire z_neg;

	// axis enable vector and combined decision
	wire [2:0] axis_en;
	wire [2:0] below_vec;
	wire [2:0] above_vec;
	reg cond;
	reg [2:0] hit_nxt;

	// scale a 63 mg count into output-data counts
	function [`FMTD_CMP_W-1:0] shared_scale;
		input [6:0] ths;
		input [1:0] fsr;
		reg [8:0] step;
		begin
			case (fsr)
				`FMTD_FSR_2G: step = `FMTD_STEP_2G;
				`FMTD_FSR_4G: step = `FMTD_STEP_4G;
				default: step = `FMTD_STEP_8G;
			endcase
			shared_scale = ths * step;
		end
	endfunction

	// async assert, synchronous release of reset
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_meta_n_r <= 1'b0;
			rst_sync_n_r <= 1'b0;
		end else begin
			rst_meta_n_r <= 1'b1;
			rst_sync_n_r <= rst_meta_n_r;
		end
	end

	// register writes; unmapped addresses are ignored
	always @(posedge clk or negedge rst_sync_n_r) begin
		if (!rst_sync_n_r) begin
			common_r <= `FMTD_REG_RESET;
			x_high_r <= `FMTD_REG_RESET;
			x_low_r <= 6'h00;
			y_high_r <= `FMTD_REG_RESET;
			y_low_r <= 6'h00;
			z_high_r <= 7'h00;
			z_low_r <= 6'h00;
		end else if (reg_wr_en) begin
			case (reg_addr)
				`FMTD_ADDR_COMMON: common_r <= reg_wdata;
				`FMTD_ADDR_X_HIGH: x_high_r <= reg_wdata;
				// low registers keep only the six upper bits
				`FMTD_ADDR_X_LOW: x_low_r <= reg_wdata[`FMTD_THS_LOW_MSB:`FMTD_THS_LOW_LSB];
				`FMTD_ADDR_Y_HIGH: y_high_r <= reg_wdata;
				`FMTD_ADDR_Y_LOW: y_low_r <= reg_wdata[`FMTD_THS_LOW_MSB:`FMTD_THS_LOW_LSB];
				// z top bit has no function and is not stored
				`FMTD_ADDR_Z_HIGH: z_high_r <= reg_wdata[`FMTD_THS_HIGH_MSB:0];
				`FMTD_ADDR_Z_LOW: z_low_r <= reg_wdata[`FMTD_THS_LOW_MSB:`FMTD_THS_LOW_LSB];
				default: ;
			endcase
		end
	end

	// registered read data, zero for unmapped offsets
	always @(posedge clk or negedge rst_sync_n_r) begin
		if (!rst_sync_n_r) begin
			reg_rdata <= `FMTD_RDATA_UNMAPPED;
		end else if (reg_rd_en) begin
			case (reg_addr)
				`FMTD_ADDR_COMMON: reg_rdata <= common_r;
				`FMTD_ADDR_X_HIGH: reg_rdata <= x_high_r;
				`FMTD_ADDR_X_LOW: reg_rdata <= {x_low_r, `FMTD_LOW_PAD};
				`FMTD_ADDR_Y_HIGH: reg_rdata <= y_high_r;
				`FMTD_ADDR_Y_LOW: reg_rdata <= {y_low_r, `FMTD_LOW_PAD};
				`FMTD_ADDR_Z_HIGH: reg_rdata <= {1'b0, z_high_r};
				`FMTD_ADDR_Z_LOW: reg_rdata <= {z_low_r, `FMTD_LOW_PAD};
				default: reg_rdata <= `FMTD_RDATA_UNMAPPED;
			endcase
		end
	end

	// field decode
	assign clear_mode = common_r[`FMTD_BIT_FLAG];
	assign shared_ths = common_r[`FMTD_THS_SHARED_MSB:0];
	// flags exported so a supervisor can spot a forbidden pairing
	assign per_axis_mode = x_high_r[`FMTD_BIT_FLAG];
	assign transient_share = y_high_r[`FMTD_BIT_FLAG];

	// assemble 13-bit per-axis thresholds
	assign x_ths = {x_high_r[`FMTD_THS_HIGH_MSB:0], x_low_r};
	assign y_ths = {y_high_r[`FMTD_THS_HIGH_MSB:0], y_low_r};
	assign z_ths = {z_high_r, z_low_r};

	// shared threshold scaled to the current data range
	assign shared_eff = shared_scale(shared_ths, full_scale_range);

	// per-axis values already in data counts, no scaling
	assign x_eff = per_axis_mode ? {3'h0, x_ths} : shared_eff;
	assign y_eff = per_axis_mode ? {3'h0, y_ths} : shared_eff;
	assign z_eff = per_axis_mode ? {3'h0, z_ths} : shared_eff;

	// x axis comparator
	fmtd_axis_cmp u_cmp_x (
		.accel(accel_x),
		.threshold(x_eff),
		.below(x_below),
		.above(x_above),
		.negative(x_neg)
	);

	// y axis comparator
	fmtd_axis_cmp u_cmp_y (
		.accel(accel_y),
		.threshold(y_eff),
		.below(y_below),
		.above(y_above),
		.negative(y_neg)
	);

	// z axis comparator
	fmtd_axis_cmp u_cmp_z (
		.accel(accel_z),
		.threshold(z_eff),
		.below(z_below),
		.above(z_above),
		.negative(z_neg)
	);

	// gather per-axis results in z,y,x order
	assign axis_en = {z_enable, y_enable, x_enable};
	assign below_vec = {z_below, y_below, x_below};
	assign above_vec = {z_above, y_above, x_above};

	// one decision path serves both threshold modes
	always @* begin
		cond = 1'b0;
		hit_nxt = 3'h0;
		if (motion_select) begin
			// any enabled axis above its threshold
			hit_nxt = above_vec & axis_en;
			cond = |hit_nxt;
		end else begin
			// every enabled axis below; no axis enabled means no event
			hit_nxt = below_vec & axis_en;
			cond = (axis_en != 3'h0) && ((below_vec | ~axis_en) == 3'h7);
		end
	end

	// per-axis hit and sign captured each sample
	always @(posedge clk or negedge rst_sync_n_r) begin
		if (!rst_sync_n_r) begin
			axis_hit_r <= 3'h0;
			axis_negative_r <= 3'h0;
		end else if (sample_valid) begin
			axis_hit_r <= hit_nxt;
			// sign shown only for enabled axes
			axis_negative_r <= {z_neg, y_neg, x_neg} & axis_en;
		end
	end

	// debounce counter; clear mode same for either threshold mode
	fmtd_debounce #(
		.CNT_W(CNT_W)
	) u_debounce (
		.clk(clk),
		.rst_n(rst_sync_n_r),
		.sample_valid(sample_valid),
		.cond(cond),
		.clear_mode(clear_mode),
		.target(debounce_target),
		.count_r(debounce_count),
		.event_r(event_active)
	);

endmodule // fmtd_top

`default_nettype wire

//--- hdl/fmtd_defines.vh
// Functional notes
// - clear mode one: counter zeroed on miss
// - clear mode zero: counter decrements, floor zero
// - clear mode same for shared, per-axis thresholds
// - shared threshold 7-bit, 63 mg, reset zero
// - select zero: all axes use shared threshold
// - select one: per-axis 13-bit thresholds used
// - per-axis thresholds in output-data scale
// - high register bits [6:0] hold threshold[12:6]
// - freefall: all enabled axes below threshold
// - motion: any enabled axis above threshold
// - per-axis mode keeps same decision logic
// - event at programmed count, never beyond
// - counter steps once per output sample
// - only enabled axes join the decision
`ifndef FMTD_DEFINES_VH
`define FMTD_DEFINES_VH

// register offsets
`define FMTD_ADDR_COMMON 8'h17
`define FMTD_ADDR_X_HIGH 8'h73
`define FMTD_ADDR_X_LOW 8'h74
`define FMTD_ADDR_Y_HIGH 8'h75
`define FMTD_ADDR_Y_LOW 8'h76
`define FMTD_ADDR_Z_HIGH 8'h77
`define FMTD_ADDR_Z_LOW 8'h78

// reset values
`define FMTD_REG_RESET 8'h00
`define FMTD_RDATA_UNMAPPED 8'h00

// field positions
`define FMTD_BIT_FLAG 7
`define FMTD_THS_SHARED_MSB 6
`define FMTD_THS_HIGH_MSB 6
`define FMTD_THS_LOW_MSB 7
`define FMTD_THS_LOW_LSB 2
`define FMTD_LOW_PAD 2'h0

// widths
`define FMTD_DATA_W 14
`define FMTD_THS_W 13
`define FMTD_CMP_W 16

// output-data counts per 63 mg step, by full-scale range
`define FMTD_FSR_2G 2'h0
`define FMTD_FSR_4G 2'h1
`define FMTD_STEP_2G 9'h102
`define FMTD_STEP_4G 9'h081
`define FMTD_STEP_8G 9'h040

`endif

//--- hdl/fmtd_axis_cmp.v
`timescale 1ns/100ps
`default_nettype none
`include "fmtd_defines.vh"

// one axis: magnitude against an effective threshold
module fmtd_axis_cmp (
	// sample and threshold
	input wire signed [`FMTD_DATA_W-1:0] accel,
	input wire [`FMTD_CMP_W-1:0] threshold,
	// comparison results
	output wire below,
	output wire above,
	output wire negative
);

	// magnitude; full negative scale still fits unsigned
	wire [`FMTD_DATA_W-1:0] mag;
	// zero-extended magnitude for compare
	wire [`FMTD_CMP_W-1:0] mag_ext;

	assign negative = accel[`FMTD_DATA_W-1];
	assign mag = negative ? (~accel + 1'b1) : accel;
	assign mag_ext = {{(`FMTD_CMP_W-`FMTD_DATA_W){1'b0}}, mag};
	// equal to threshold counts as neither low nor high
	assign below = (mag_ext < threshold);
	assign above = (mag_ext > threshold);

endmodule // fmtd_axis_cmp

`default_nettype wire

//--- hdl/fmtd_debounce.v
`timescale 1ns/100ps
`default_nettype none
`include "fmtd_defines.vh"

// debounce counter with selectable clear mode
module fmtd_debounce #(
	parameter CNT_W = 8
) (
	// clock and synchronised reset
	input wire clk,
	input wire rst_n,
	// sample step and condition
	input wire sample_valid,
	input wire cond,
	input wire clear_mode,
	input wire [CNT_W-1:0] target,
	// state
	output reg [CNT_W-1:0] count_r,
	output reg event_r
);

	// next count value
	reg [CNT_W-1:0] count_nxt;

	// next count, shared by both threshold modes
	always @* begin
		count_nxt = count_r;
		if (cond) begin
			// saturate at target, never beyond
			if (count_r < target)
				count_nxt = count_r + 1'b1;
		end else if (clear_mode) begin
			count_nxt = {CNT_W{1'b0}};
		end else if (count_r != {CNT_W{1'b0}}) begin
			count_nxt = count_r - 1'b1;
		end
	end

	// advance only on an output sample
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count_r <= {CNT_W{1'b0}};
			event_r <= 1'b0;
		end else if (sample_valid) begin
			count_r <= count_nxt;
			event_r <= cond && (count_nxt == target);
		end
	end

endmodule // fmtd_debounce

`default_nettype wire

//--- sim/fmtd_checker.sv
`timescale 1ns/100ps
`default_nettype none
// watches top ports only
module fmtd_checker #(parameter CNT_W = 8) (
	// clock, reset
	input wire logic clk,
	input wire logic rstn,
	// register bus
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	// sample path
	input wire logic sample_valid,
	input wire logic x_enable,
	input wire logic [CNT_W-1:0] debounce_target,
	input wire logic event_active,
	input wire logic [CNT_W-1:0] debounce_count,
	input wire logic [2:0] axis_hit_r,
	input wire logic [2:0] axis_negative_r,
	input wire logic per_axis_mode,
	input wire logic transient_share
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	property p_hold; !sample_valid |=> $stable(debounce_count) && $stable(event_active); endproperty
	a_hold: assert property (p_hold) else $error("count moved without sample");
	property p_cap; sample_valid && debounce_count == debounce_target |=> debounce_count <= $past(debounce_target);
	endproperty
	a_cap: assert property (p_cap) else $error("count passed target");
	property p_step; sample_valid |=> debounce_count == 0 || debounce_count == $past(debounce_count) + 1
		|| debounce_count + 1 == $past(debounce_count) || $stable(debounce_count); endproperty
	a_step: assert property (p_step) else $error("count step wrong");
	property p_evt; event_active |-> debounce_count == debounce_target; endproperty
	a_evt: assert property (p_evt) else $error("event off target");
	property p_rise; $rose(event_active) |-> $past(sample_valid); endproperty
	a_rise: assert property (p_rise) else $error("event rose without sample");
	property p_sel; reg_wr_en && reg_addr == 8'h73 && reg_wdata[7] |=> per_axis_mode; endproperty
	a_sel: assert property (p_sel) else $error("select flag not set");
	property p_shr; reg_wr_en && reg_addr == 8'h75 && !reg_wdata[7] |=> !transient_share; endproperty
	a_shr: assert property (p_shr) else $error("share flag not cleared");
	property p_dis; sample_valid && !x_enable |=> axis_hit_r[0] == 1'b0 && axis_negative_r[0] == 1'b0; endproperty
	a_dis: assert property (p_dis) else $error("disabled axis reported");
	property p_low; reg_rd_en && reg_addr == 8'h74 |=> reg_rdata[1:0] == 2'h0; endproperty
	a_low: assert property (p_low) else $error("low pad bits set");
	c_evt: cover property ($rose(event_active));
	c_dec: cover property (sample_valid ##1 debounce_count + 1 == $past(debounce_count));
	c_sel: cover property ($rose(per_axis_mode));
endmodule // fmtd_checker
bind fmtd_top fmtd_checker #(.CNT_W(CNT_W)) u_chk (.clk(clk), .rstn(rstn), .reg_wr_en(reg_wr_en),
	.reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.sample_valid(sample_valid), .x_enable(x_enable), .debounce_target(debounce_target),
	.event_active(event_active), .debounce_count(debounce_count), .axis_hit_r(axis_hit_r),
	.axis_negative_r(axis_negative_r), .per_axis_mode(per_axis_mode), .transient_share(transient_share));
`default_nettype wire

//--- sim/fmtd_host.sv
`timescale 1ns/100ps
`default_nettype none
// host model: register strobes launched at the falling edge
module fmtd_host (
	// clock
	input wire logic clk,
	// register bus
	output var logic reg_wr_en = 1'b0,
	output var logic reg_rd_en = 1'b0,
	output var logic [7:0] reg_addr = 8'h00,
	output var logic [7:0] reg_wdata = 8'h00,
	input wire logic [7:0] reg_rdata
);
	logic share_r = 1'b0; // last share flag written
	// one write; select flag held off while share is on
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		if (a == 8'h75) share_r = d[7];
		if (a == 8'h73 && share_r) d[7] = 1'b0;
		reg_addr = a;
		reg_wdata = d;
		reg_wr_en = 1'b1;
		@(negedge clk);
		reg_wr_en = 1'b0;
		reg_wdata = ~d; // no stale data left on the bus
	endtask
	// one read; data seen the cycle after the strobe
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_rd_en = 1'b1;
		@(negedge clk);
		reg_rd_en = 1'b0;
		d = reg_rdata;
	endtask
endmodule // fmtd_host
`default_nettype wire

//--- sim/test_fmtd_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "fmtd_defines.vh"
// bench: registers, debounce modes, thresholds
module test_fmtd_top;
	logic clk = 1'b0, rstn = 1'b0, sample_valid = 1'b0, motion_select = 1'b1;
	logic x_enable = 1'b1, y_enable = 1'b0, z_enable = 1'b0;
	logic [1:0] full_scale_range = 2'h0;
	logic [7:0] debounce_target = 8'h02, rv;
	logic signed [`FMTD_DATA_W-1:0] ax = '0, ay = '0, az = '0;
	wire logic wr_en, rd_en, event_active, per_axis_mode, transient_share;
	wire logic [7:0] addr, wdata, rdata, debounce_count;
	wire logic [2:0] axis_hit_r, axis_negative_r;
	int bad_count = 0, samples_checked = 0;
	fmtd_host host (.clk(clk), .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_addr(addr), .reg_wdata(wdata),
		.reg_rdata(rdata));
	fmtd_top dut (.clk(clk), .rstn(rstn), .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_addr(addr),
		.reg_wdata(wdata), .reg_rdata(rdata), .sample_valid(sample_valid), .accel_x(ax), .accel_y(ay),
		.accel_z(az), .motion_select(motion_select), .x_enable(x_enable), .y_enable(y_enable),
		.z_enable(z_enable), .full_scale_range(full_scale_range), .debounce_target(debounce_target),
		.event_active(event_active), .debounce_count(debounce_count), .axis_hit_r(axis_hit_r),
		.axis_negative_r(axis_negative_r), .per_axis_mode(per_axis_mode), .transient_share(transient_share));
	initial forever #12.5 clk = ~clk;
	task chk(input logic [15:0] s, input logic [15:0] e);
		samples_checked++;
		if (s !== e) begin
			bad_count++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// one sample pulse, outputs settled on return
	task smp(input int x, input int y, input int z);
		@(negedge clk);
		ax = x[13:0];
		ay = y[13:0];
		az = z[13:0];
		sample_valid = 1'b1;
		@(negedge clk);
		sample_valid = 1'b0;
	endtask
	task t_regs;
		logic [7:0] a [7] = '{8'h17, 8'h73, 8'h74, 8'h75, 8'h76, 8'h77, 8'h78};
		logic [7:0] w [7] = '{8'hff, 8'h7f, 8'hff, 8'h7f, 8'hff, 8'hff, 8'hff};
		logic [7:0] m [7] = '{8'hff, 8'h7f, 8'hfc, 8'h7f, 8'hfc, 8'h7f, 8'hfc};
		for (int i = 0; i < 7; i++) begin
			host.rd(a[i], rv);
			chk(rv, 8'h00);
			host.wr(a[i], w[i]);
			host.rd(a[i], rv);
			chk(rv, m[i]);
			host.wr(a[i], 8'h00);
		end
		host.wr(8'h20, 8'hff);
		host.rd(8'h20, rv);
		chk(rv, 8'h00);
		host.wr(8'h75, 8'h80);
		chk(transient_share, 1);
		host.wr(8'h75, 8'h00);
		$display("t_regs done");
	endtask
	// motion at zero threshold, both clear modes
	task t_deb;
		host.wr(8'h17, 8'h80);
		smp(5, 0, 0);
		chk({debounce_count, 7'h0, event_active}, 16'h0100);
		smp(5, 0, 0);
		smp(5, 0, 0);
		chk({debounce_count, 7'h0, event_active}, 16'h0201);
		repeat (3) @(negedge clk);
		chk(debounce_count, 8'h02);
		smp(0, 0, 0);
		chk({debounce_count, 7'h0, event_active}, 16'h0000);
		host.wr(8'h17, 8'h00);
		smp(5, 0, 0);
		smp(5, 0, 0);
		smp(0, 0, 0);
		chk({debounce_count, 7'h0, event_active}, 16'h0100);
		smp(0, 0, 0);
		smp(0, 0, 0);
		chk(debounce_count, 8'h00);
		$display("t_deb done");
	endtask
	// shared threshold of one step at each range
	task t_ths;
		host.wr(8'h17, 8'h81);
		smp(258, 0, 0);
		chk(axis_hit_r, 3'h0);
		smp(-259, 0, 0);
		chk({axis_hit_r, axis_negative_r}, 6'h09);
		full_scale_range = 2'h1;
		y_enable = 1'b1;
		smp(0, 130, 0);
		chk({axis_hit_r, axis_negative_r}, 6'h10);
		full_scale_range = 2'h2;
		z_enable = 1'b1;
		smp(0, 0, -65);
		chk({axis_hit_r, axis_negative_r}, 6'h24);
		{full_scale_range, y_enable, z_enable} = '0;
		$display("t_ths done");
	endtask
	// per-axis threshold of 65 on x
	task t_axis;
		host.wr(8'h73, 8'h81);
		host.wr(8'h74, 8'h04);
		chk(per_axis_mode, 1);
		smp(66, 0, 0);
		chk(axis_hit_r, 3'h1);
		smp(65, 0, 0);
		chk({axis_hit_r, debounce_count}, 11'h000);
		motion_select = 1'b0;
		host.wr(8'h17, 8'h01);
		smp(64, 8000, 0);
		chk({axis_hit_r, debounce_count}, 11'h101);
		smp(64, 8000, 0);
		smp(70, 8000, 0);
		chk({debounce_count, 7'h0, event_active}, 16'h0100);
		y_enable = 1'b1;
		smp(64, 8000, 0);
		chk(debounce_count, 8'h00);
		// no axis enabled: a negative x takes no part and no event builds
		{x_enable, y_enable} = 2'h0;
		smp(-5, 0, 0);
		chk({axis_hit_r, axis_negative_r, debounce_count}, 14'h0000);
		x_enable = 1'b1;
		$display("t_axis done");
	endtask
	task print_verdict;
		$display("checked %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		#1000000;
		bad_count++;
		print_verdict;
	end
	initial begin
		repeat (2) @(negedge clk);
		rstn = 1'b1;
		repeat (3) @(negedge clk);
		t_regs;
		t_deb;
		t_ths;
		t_axis;
		print_verdict;
	end
endmodule // test_fmtd_top
`default_nettype wire
